// *** src/rec_consts.svh ***
// Constants of the triggered sample recorder: offsets, fields, resets, timing
// Functional notes
// - Each stored entry is the 16-bit selected value present at its sampling instant.
// - One recording keeps at most 60 samples.
// - A recording is launched by an edge on the binary trigger input.
// - Trigger edge is selectable rising or falling; rising after reset.
// - Sampling interval is 0.1 s to 50 s in 0.1 s steps; default 0.1 s.
// - Window length equals sampling interval times 60 stored values.
// - The pre-trigger share of the window holds samples taken before the trigger.
// - Pre-trigger is 0 to 100 percent in 5 percent steps; default 0.
// - Every qualifying trigger edge outside the post-trigger phase starts a fresh curve replacing the old one.
// - Sampling and storing run on their own, independent of any bus traffic; the code stores nothing in ST_HOLD until a CTRL rearm write or a trigger.
`ifndef REC_CONSTS_SVH
`define REC_CONSTS_SVH

// Timing
`define REC_CLK_PERIOD_NS    10
`define REC_TICK_NS          100000000
`define REC_INTERVAL_MAX     9'd500
`define REC_INTERVAL_RST     9'h001

// Capture memory and pre-trigger
`define REC_DEPTH            6'd60
`define REC_LAST_SLOT        6'd59
`define REC_PRE_MAX_STEPS    5'd20
`define REC_PRE_RST          5'h00

// Register offsets (byte addresses)
`define REC_CTRL_OFS         12'h000
`define REC_INTERVAL_OFS     12'h004
`define REC_PRETRIG_OFS      12'h008
`define REC_STATUS_OFS       12'h00C
`define REC_SAMPLE_BASE      12'h100
`define REC_SAMPLE_LAST      12'h1EC

// Field positions
`define REC_CTRL_EDGE_BIT    0
`define REC_CTRL_REARM_BIT   1
`define REC_STAT_STATE_LSB   0
`define REC_STAT_FILL_LSB    8
`define REC_STAT_PRE_LSB     16
`define REC_STAT_VALID_BIT   24
`define REC_CTRL_EDGE_RST    1'b0

`endif

// *** src/rec_pkg.sv ***
// Types shared by the triggered sample recorder
package rec_pkg;

    typedef logic [15:0] sample_t;
    typedef logic [5:0]  slot_t;

    typedef enum logic [2:0] {
        ST_PRE  = 3'b001,
        ST_POST = 3'b010,
        ST_HOLD = 3'b100
    } rec_state_t;

endpackage

// *** src/sample_store.sv ***
// Sixty-entry capture memory with one write port and a registered read port
`include "rec_consts.svh"

module sample_store
    import rec_pkg::*;
(
    // Clock
    input  wire logic    pclk,
    // Write port
    input  wire logic    wr_en,
    input  wire slot_t   wr_slot,
    input  wire sample_t wr_data,
    // Read port
    input  wire slot_t   rd_slot,
    output sample_t      rd_data
);

    sample_t mem [0:59];

    // Write slot indices are always kept below the depth by the owner
    always_ff @(posedge pclk) begin
        if (wr_en && (wr_slot < `REC_DEPTH)) begin
            mem[wr_slot] <= wr_data;
        end
    end

    // No reset on the array; the read register has none either, unused slots read stale
    always_ff @(posedge pclk) begin
        if (rd_slot < `REC_DEPTH) begin
            rd_data <= mem[rd_slot];
        end else begin
            rd_data <= 16'h0000;
        end
    end

endmodule

// *** src/triggered_sample_recorder.sv ***
// Triggered sample recorder: interval timer, trigger edge, ring capture and APB registers
//
// The implementer's own choices: the placing of the registers and the APB register port.
`include "rec_consts.svh"

module triggered_sample_recorder
    import rec_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `REC_TICK_NS / `REC_CLK_PERIOD_NS
)
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Internal signal network
    input  wire sample_t     sample_value,
    input  wire logic        trigger_in,
    // Status
    output logic             rec_busy,
    output logic             curve_valid
);

    // Wrap-around addition inside the sixty slots
    function automatic slot_t slot_add(input slot_t a, input slot_t b);
        logic [6:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s >= {1'b0, `REC_DEPTH}) begin
            s = s - {1'b0, `REC_DEPTH};
        end
        return s[5:0];
    endfunction

    function automatic logic is_sample_addr(input logic [11:0] a);
        return (a >= `REC_SAMPLE_BASE) && (a <= `REC_SAMPLE_LAST) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic is_reg_addr(input logic [11:0] a);
        return (a == `REC_CTRL_OFS) || (a == `REC_INTERVAL_OFS) ||
               (a == `REC_PRETRIG_OFS) || (a == `REC_STATUS_OFS);
    endfunction

    // Configuration
    logic        edge_fall_ff;
    logic [8:0]  interval_ff;
    logic [4:0]  pre_steps_ff;

    // Time base
    logic [31:0] tick_cnt_ff;
    logic [8:0]  ival_cnt_ff;
    logic        tick;
    logic        sample_stb;

    // Trigger
    logic        trig_prev_ff;
    logic        trig_evt;
    logic        trig_take;

    // Capture state
    rec_state_t  state_ff;
    slot_t       wr_ptr_ff;
    slot_t       fill_ff;
    slot_t       post_left_ff;
    slot_t       start_ff;
    slot_t       pre_used_ff;
    logic        curve_valid_ff;
    slot_t       pre_n;
    slot_t       avail;
    slot_t       pre_take;

    // Memory ports
    logic        mem_we;
    sample_t     mem_rdata;
    slot_t       rd_slot;
    slot_t       rd_index;

    // Bus
    logic        access;
    logic        wait_ff;
    logic        bus_hit;
    logic        wr_commit;
    logic        rearm;
    logic [31:0] prdata_ff;
    logic        pslverr_ff;
    logic [31:0] rd_mux;
    logic [8:0]  nxt_interval;
    logic [4:0]  nxt_pre_steps;

    // ---------------- Time base ----------------

    // Free-running 0.1 s tick; restarted by a trigger so post samples align to it
    assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_ff <= 32'h00000000;
        end else if (trig_take || tick) begin
            tick_cnt_ff <= 32'h00000000;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
        end
    end

    // Interval is counted in ticks, so the window spans interval times sixty
    assign sample_stb = tick && ((ival_cnt_ff + 9'h001) >= interval_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ival_cnt_ff <= 9'h000;
        end else if (trig_take || sample_stb) begin
            ival_cnt_ff <= 9'h000;
        end else if (tick) begin
            ival_cnt_ff <= ival_cnt_ff + 9'h001;
        end
    end

    // ---------------- Trigger ----------------

    // Trigger comes from logic on this clock, so it is not resynchronised
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev_ff <= 1'b0;
        end else begin
            trig_prev_ff <= trigger_in;
        end
    end

    assign trig_evt  = edge_fall_ff ? (trig_prev_ff && !trigger_in)
                                    : (!trig_prev_ff && trigger_in);
    // A trigger during the post phase belongs to the running recording and is ignored
    assign trig_take = trig_evt && (state_ff != ST_POST);

    // ---------------- Capture ----------------

    // 5 percent of sixty is three samples per step
    assign pre_n    = {1'b0, pre_steps_ff} + {pre_steps_ff, 1'b0};
    // Only samples actually gathered since arming can serve as pre-trigger history
    assign avail    = (state_ff == ST_PRE) ? fill_ff : 6'h00;
    assign pre_take = (avail < pre_n) ? avail : pre_n;

    always_comb begin
        mem_we = 1'b0;
        if (trig_take) begin
            mem_we = (pre_take != `REC_DEPTH);
        end else if (sample_stb && (state_ff != ST_HOLD)) begin
            mem_we = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff     <= ST_PRE;
            post_left_ff <= 6'h00;
        end else if (trig_take) begin
            // Trigger sample is the first post sample unless the window is all history
            if ((pre_take == `REC_DEPTH) || (pre_take == `REC_LAST_SLOT)) begin
                state_ff     <= ST_HOLD;
                post_left_ff <= 6'h00;
            end else begin
                state_ff     <= ST_POST;
                post_left_ff <= `REC_LAST_SLOT - pre_take;
            end
        end else begin
            case (state_ff)
                ST_POST: begin
                    if (sample_stb) begin
                        post_left_ff <= post_left_ff - 6'h01;
                        if (post_left_ff == 6'h01) begin
                            state_ff <= ST_HOLD;
                        end
                    end
                end
                ST_HOLD: begin
                    if (rearm) begin
                        state_ff <= ST_PRE;
                    end
                end
                default: begin
                    state_ff <= state_ff;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_ff <= 6'h00;
        end else if (mem_we) begin
            wr_ptr_ff <= slot_add(wr_ptr_ff, 6'h01);
        end
    end

    // Ring fill level saturates at the depth while waiting for a trigger
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_ff <= 6'h00;
        end else if (trig_take || (rearm && (state_ff == ST_HOLD))) begin
            fill_ff <= 6'h00;
        end else if (sample_stb && (state_ff == ST_PRE) && (fill_ff != `REC_DEPTH)) begin
            fill_ff <= fill_ff + 6'h01;
        end
    end

    // Oldest sample of the new curve sits pre_take slots behind the write pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_ff    <= 6'h00;
            pre_used_ff <= 6'h00;
        end else if (trig_take) begin
            start_ff    <= slot_add(wr_ptr_ff, `REC_DEPTH - pre_take);
            pre_used_ff <= pre_take;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            curve_valid_ff <= 1'b0;
        end else if (trig_take || (rearm && (state_ff == ST_HOLD))) begin
            curve_valid_ff <= 1'b0;
        end else if ((state_ff == ST_POST) && (sample_stb && (post_left_ff == 6'h01))) begin
            curve_valid_ff <= 1'b1;
        end else if ((state_ff == ST_PRE) && (pre_take == `REC_DEPTH)) begin
            curve_valid_ff <= curve_valid_ff;
        end
    end

    assign rec_busy    = (state_ff == ST_POST);
    assign curve_valid = curve_valid_ff || (state_ff == ST_HOLD);

    // ---------------- Memory ----------------

    // Software reads entries in time order; the ring start is hidden from it
    assign rd_index = slot_t'((paddr - `REC_SAMPLE_BASE) >> 2);
    assign rd_slot  = slot_add(start_ff, rd_index);

    sample_store u_store (
        .pclk    (pclk),
        .wr_en   (mem_we),
        .wr_slot (wr_ptr_ff),
        .wr_data (sample_value),
        .rd_slot (rd_slot),
        .rd_data (mem_rdata)
    );

    // ---------------- APB slave ----------------

    // One wait state lets the registered memory read settle before data is latched
    assign access    = psel && penable;
    assign bus_hit   = is_reg_addr(paddr) || is_sample_addr(paddr);
    assign pready    = access && wait_ff;
    assign wr_commit = pready && pwrite && bus_hit;
    assign rearm     = wr_commit && (paddr == `REC_CTRL_OFS) && pwdata[`REC_CTRL_REARM_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_ff <= 1'b0;
        end else begin
            wait_ff <= access && !wait_ff;
        end
    end

    always_comb begin
        rd_mux = 32'h00000000;
        if (paddr == `REC_CTRL_OFS) begin
            rd_mux[`REC_CTRL_EDGE_BIT] = edge_fall_ff;
        end else if (paddr == `REC_INTERVAL_OFS) begin
            rd_mux[8:0] = interval_ff;
        end else if (paddr == `REC_PRETRIG_OFS) begin
            rd_mux[4:0] = pre_steps_ff;
        end else if (paddr == `REC_STATUS_OFS) begin
            rd_mux[`REC_STAT_STATE_LSB +: 3] = state_ff;
            rd_mux[`REC_STAT_FILL_LSB +: 6]  = fill_ff;
            rd_mux[`REC_STAT_PRE_LSB +: 6]   = pre_used_ff;
            rd_mux[`REC_STAT_VALID_BIT]      = curve_valid;
        end else if (is_sample_addr(paddr)) begin
            rd_mux[15:0] = mem_rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end else if (access && !wait_ff) begin
            prdata_ff  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_ff <= !bus_hit;
        end
    end

    assign prdata  = prdata_ff;
    assign pslverr = pready && pslverr_ff;

    // Out-of-range settings are clamped rather than refused
    always_comb begin
        nxt_interval = pwdata[8:0];
        if (nxt_interval == 9'h000) begin
            nxt_interval = 9'h001;
        end else if (nxt_interval > `REC_INTERVAL_MAX) begin
            nxt_interval = `REC_INTERVAL_MAX;
        end
        nxt_pre_steps = pwdata[4:0];
        if (nxt_pre_steps > `REC_PRE_MAX_STEPS) begin
            nxt_pre_steps = `REC_PRE_MAX_STEPS;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_fall_ff <= `REC_CTRL_EDGE_RST;
            interval_ff  <= `REC_INTERVAL_RST;
            pre_steps_ff <= `REC_PRE_RST;
        end else if (wr_commit) begin
            if (paddr == `REC_CTRL_OFS) begin
                edge_fall_ff <= pwdata[`REC_CTRL_EDGE_BIT];
            end else if (paddr == `REC_INTERVAL_OFS) begin
                interval_ff <= nxt_interval;
            end else if (paddr == `REC_PRETRIG_OFS) begin
                pre_steps_ff <= nxt_pre_steps;
            end
        end
    end

endmodule

// *** testbench/rec_properties.sv ***
// Port-level checks of the triggered sample recorder
module rec_properties
    import rec_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 4
)
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Signal network and status
    input wire sample_t     sample_value,
    input wire logic        trigger_in,
    input wire logic        rec_busy,
    input wire logic        curve_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        edge_ff;
    logic        trig_ff;
    logic [8:0]  ivl_ff;
    logic [31:0] busy_cnt_ff;
    wire         wr_done = psel && penable && pready && pwrite;
    wire         qual = (trigger_in != trig_ff) && (trigger_in != edge_ff);

    // Shadow of edge select and interval, clamped like the register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_ff <= 1'b0;
            trig_ff <= 1'b0;
            ivl_ff <= 9'h001;
            busy_cnt_ff <= 32'h0;
        end else begin
            trig_ff <= trigger_in;
            busy_cnt_ff <= rec_busy ? busy_cnt_ff + 32'h1 : 32'h0;
            if (wr_done && paddr == 12'h000) edge_ff <= pwdata[0];
            if (wr_done && paddr == 12'h004) begin
                ivl_ff <= (pwdata[8:0] == 9'h000) ? 9'h001 :
                          (pwdata[8:0] > 9'h1F4) ? 9'h1F4 : pwdata[8:0];
            end
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_busy_no_valid: assert property (rec_busy |-> !curve_valid)
        else $error("busy and valid high together");
    a_end_valid: assert property ($fell(rec_busy) |-> curve_valid)
        else $error("curve not valid after collection");
    a_busy_needs_edge: assert property (
        $rose(rec_busy) |-> $past(trigger_in) != $past(trigger_in, 2))
        else $error("collection started without trigger change");
    a_edge_starts: assert property ((qual && !rec_busy) |=> (rec_busy || curve_valid))
        else $error("qualified edge did not start a recording");
    a_new_curve: assert property ((qual && curve_valid && !rec_busy) |=> !curve_valid)
        else $error("old curve kept after new trigger");
    a_hold_frozen: assert property (
        (curve_valid && !rec_busy && $stable(trigger_in) && !(wr_done && paddr == 12'h000))
        |=> curve_valid)
        else $error("held curve released without cause");
    a_post_bounded: assert property (
        rec_busy |-> busy_cnt_ff <= 59 * ivl_ff * TICK_CYCLES)
        else $error("post-trigger phase longer than window");
    a_slot_limit: assert property ((pready && paddr == 12'h1F0) |-> pslverr)
        else $error("slot past the sixtieth accepted");
endmodule

// *** testbench/sig_source.sv ***
// Model of the internal signal network feeding the recorder
module sig_source
    import rec_pkg::*;
(
    // Clock
    input  wire logic pclk,
    // Bench control
    input  wire logic req_level,
    // Signal network
    output sample_t   sample_value,
    output logic      trigger_in,
    output sample_t   trig_val
);
    timeunit 1ns;
    timeprecision 1ps;
    // Value moves every cycle so each slot betrays its own sampling instant
    initial begin
        sample_value = 16'h0000;
        trigger_in = 1'b0;
        trig_val = 16'h0000;
        forever begin
            @(posedge pclk);
            sample_value <= sample_value + 16'h0001;
            trigger_in <= req_level;
            if (req_level != trigger_in) trig_val <= sample_value + 16'h0001;
        end
    end
endmodule

// *** testbench/test_triggered_sample_recorder.sv ***
// Testbench of the triggered sample recorder
module test_triggered_sample_recorder
    import rec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned TICK = 4;
    localparam int PT_IN[3] = '{21, 20, 1};
    localparam int PT_EX[3] = '{20, 20, 1};
    localparam int IV_IN[4] = '{0, 501, 500, 2};
    localparam int IV_EX[4] = '{1, 500, 500, 2};
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    sample_t     sample_value;
    logic        trigger_in;
    logic        rec_busy;
    logic        curve_valid;
    logic        req_level = 1'b0;
    sample_t     trig_val;
    sample_t     trig_exp;
    logic [31:0] rdat;
    logic        rerr;
    sample_t     ent [60];
    int          err_total = 0;
    int          check_count = 0;

    always #5 pclk = ~pclk;

    triggered_sample_recorder #(.TICK_CYCLES(TICK)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_value(sample_value), .trigger_in(trigger_in), .rec_busy(rec_busy),
        .curve_valid(curve_valid));

    sig_source src_u (.pclk(pclk), .req_level(req_level), .sample_value(sample_value),
        .trigger_in(trigger_in), .trig_val(trig_val));

    task automatic stop_test();
        if (err_total == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask

    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(32'(n < 20), 32'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_rd(input logic [11:0] a, input int d, input int exp);
        acc(1'b1, a, 32'(d));
        acc(1'b0, a, 32'h0);
        chk(rdat, 32'(exp));
    endtask

    // Bounded wait on busy (which=0) or curve valid (which=1)
    task automatic wait_sig(input logic which, input int lim);
        int n;
        n = 0;
        while (((which ? curve_valid : rec_busy) !== 1'b1) && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n < lim), 32'h1);
    endtask

    task automatic check_curve(input int pre, input int ivl);
        for (int i = 0; i < 60; i++) begin
            acc(1'b0, 12'h100 + 12'(4 * i), 32'h0);
            ent[i] = rdat[15:0];
        end
        // The step into the trigger sample follows the trigger, not the tick
        for (int i = 0; i < 59; i++) begin
            if (i + 1 != pre) chk(32'(sample_t'(ent[i+1] - ent[i])), 32'(ivl * TICK));
        end
        if (pre < 60) chk(32'(ent[pre]), 32'(trig_exp));
        acc(1'b0, 12'h00C, 32'h0);
        chk({rdat[24], rdat[21:16], rdat[2:0]}, {1'b1, 6'(pre), 3'h4});
    endtask

    initial begin
        int n;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        acc(1'b0, 12'h000, 32'h0);
        chk(rdat, 32'h0);
        acc(1'b0, 12'h004, 32'h0);
        chk(rdat, 32'h1);
        acc(1'b0, 12'h008, 32'h0);
        chk(rdat, 32'h0);
        acc(1'b0, 12'h00C, 32'h0);
        chk({rdat[24], rdat[2:0]}, 4'h1);
        acc(1'b0, 12'h1F0, 32'h0);
        chk(rerr, 1'b1);
        acc(1'b0, 12'h1EC, 32'h0);
        chk(rerr, 1'b0);
        for (int i = 0; i < 3; i++) wr_rd(12'h008, PT_IN[i], PT_EX[i]);
        for (int i = 0; i < 4; i++) wr_rd(12'h004, IV_IN[i], IV_EX[i]);
        // Five intervals of history at the new rate
        repeat (40) @(posedge pclk);
        req_level <= 1'b1;
        wait_sig(1'b0, 10);
        trig_exp = trig_val;
        req_level <= 1'b0;
        repeat (3) @(posedge pclk);
        req_level <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(rec_busy, 1'b1);
        wait_sig(1'b1, 1000);
        check_curve(3, 2);
        wr_rd(12'h008, 0, 0);
        wr_rd(12'h004, 1, 1);
        wr_rd(12'h000, 1, 1);
        req_level <= 1'b0;
        wait_sig(1'b0, 10);
        trig_exp = trig_val;
        wait_sig(1'b1, 400);
        check_curve(0, 1);
        wr_rd(12'h008, 20, 20);
        wr_rd(12'h000, 3, 1);
        chk(curve_valid, 1'b0);
        n = 0;
        do begin
            acc(1'b0, 12'h00C, 32'h0);
            n++;
        end while (rdat[13:8] < 60 && n < 100);
        chk(rdat[13:8], 6'd60);
        req_level <= 1'b1;
        repeat (3) @(posedge pclk);
        req_level <= 1'b0;
        wait_sig(1'b1, 10);
        chk(rec_busy, 1'b0);
        check_curve(60, 1);
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        stop_test();
    end
endmodule

bind triggered_sample_recorder rec_properties #(.TICK_CYCLES(TICK_CYCLES)) prop_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_value(sample_value), .trigger_in(trigger_in), .rec_busy(rec_busy),
    .curve_valid(curve_valid));
